// >>> rtl/cammc_top.sv
// design: mode control, compare, capture and pin logic of a six-module counter array
`timescale 1ns/1ps
`default_nettype none

// Operation
// - wide bit picks 16-bit, else 8-11-bit cycle
// - comparator works only when its enable set
// - rising pin edge captures counter value
// - falling pin edge captures counter value
// - match sets module capture compare flag
// - toggle inverts module pin on match
// - toggle plus pulse width gives frequency output
// - pulse width enable drives modulated output
// - flag and enable raise module interrupt
// - watchdog locks module 5 mode register
// - low byte register accesses counter bits 7:0
// - watchdog blocks writes to counter low byte
// - low byte read snapshots high byte
// - compare low byte write clears comparator enable
// - compare high byte write sets comparator enable
module cammc_top #(
  parameter int NUM_MODULES = 6,
  parameter int CYCLE_BITS  = 8
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_clk_en,
  input  wire cammc_pkg::cammc_sfr_type i_sfr,
  input  wire logic [NUM_MODULES-1:0] i_module_io_pin,
  output logic      [7:0]             o_rdata,
  output logic      [NUM_MODULES-1:0] o_module_io_pin,
  output logic      [NUM_MODULES-1:0] o_irq
);
  // elaboration checks: the decoders and the flag register layout serve six modules only
  if (NUM_MODULES != 6) begin : g_bad_modules
    $error("six modules are decoded");
  end
  if (CYCLE_BITS < 8 || CYCLE_BITS > 11) begin : g_bad_cycle
    $error("cycle length must be 8 to 11 bits");
  end

  // ********************************************************
  // decode helpers
  // ********************************************************
  // index of a mode register address, NUM_MODULES when none
  function automatic int mode_index(input logic [7:0] a);
    unique case (a)
      cammc_pkg::ADDR_MODE0: mode_index = 0;
      cammc_pkg::ADDR_MODE1: mode_index = 1;
      cammc_pkg::ADDR_MODE2: mode_index = 2;
      cammc_pkg::ADDR_MODE3: mode_index = 3;
      cammc_pkg::ADDR_MODE4: mode_index = 4;
      cammc_pkg::ADDR_MODE5: mode_index = 5;
      default:               mode_index = 6;
    endcase
  endfunction

  function automatic int cc_low_index(input logic [7:0] a);
    unique case (a)
      cammc_pkg::ADDR_CC_LOW0: cc_low_index = 0;
      cammc_pkg::ADDR_CC_LOW1: cc_low_index = 1;
      cammc_pkg::ADDR_CC_LOW2: cc_low_index = 2;
      cammc_pkg::ADDR_CC_LOW3: cc_low_index = 3;
      cammc_pkg::ADDR_CC_LOW4: cc_low_index = 4;
      cammc_pkg::ADDR_CC_LOW5: cc_low_index = 5;
      default:                 cc_low_index = 6;
    endcase
  endfunction

  function automatic int cc_high_index(input logic [7:0] a);
    unique case (a)
      cammc_pkg::ADDR_CC_HIGH0: cc_high_index = 0;
      cammc_pkg::ADDR_CC_HIGH1: cc_high_index = 1;
      cammc_pkg::ADDR_CC_HIGH2: cc_high_index = 2;
      cammc_pkg::ADDR_CC_HIGH3: cc_high_index = 3;
      cammc_pkg::ADDR_CC_HIGH4: cc_high_index = 4;
      cammc_pkg::ADDR_CC_HIGH5: cc_high_index = 5;
      default:                  cc_high_index = 6;
    endcase
  endfunction

  // ********************************************************
  // state
  // ********************************************************
  cammc_pkg::cammc_mode_type             mode_q [NUM_MODULES];
  logic [15:0]                           cc_q   [NUM_MODULES];
  logic [15:0]                           count_q;
  logic [7:0]                            snap_high_q;
  logic [7:0]                            ctrl_q;
  logic [NUM_MODULES-1:0]                flag_q;
  logic [NUM_MODULES-1:0]                pin_meta_q;
  logic [NUM_MODULES-1:0]                pin_sync_q;
  logic [NUM_MODULES-1:0]                pin_prev_q;
  logic                                  wdog_en;
  logic                                  wr_ok;

  assign wdog_en = ctrl_q[cammc_pkg::CTRL_WDOG_BIT];
  assign wr_ok   = i_clk_en & i_sfr.wr;

  // ********************************************************
  // pin synchroniser
  // ********************************************************
  // two stages; only the second stage feeds the edge detector
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_prev_q <= '0;
    end else if (i_clk_en) begin
      pin_meta_q <= i_module_io_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // ********************************************************
  // control register (watchdog enable only)
  // ********************************************************
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= cammc_pkg::CTRL_RESET;
    end else if (wr_ok && i_sfr.addr == cammc_pkg::ADDR_CTRL) begin
      // other bits frozen while the watchdog runs, only the enable may be cleared
      if (wdog_en) begin
        ctrl_q[cammc_pkg::CTRL_WDOG_BIT] <= i_sfr.wdata[cammc_pkg::CTRL_WDOG_BIT];
      end else begin
        ctrl_q <= i_sfr.wdata;
      end
    end
  end

  // ********************************************************
  // shared counter, free running at the core clock
  // ********************************************************
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      count_q <= cammc_pkg::COUNT_RESET;
    end else if (i_clk_en) begin
      if (i_sfr.wr && !wdog_en && i_sfr.addr == cammc_pkg::ADDR_CNT_LOW) begin
        count_q[7:0] <= i_sfr.wdata;
      end else if (i_sfr.wr && !wdog_en && i_sfr.addr == cammc_pkg::ADDR_CNT_HIGH) begin
        count_q[15:8] <= i_sfr.wdata;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // high byte copied on every low byte read so a two-byte read is coherent
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      snap_high_q <= 8'h00;
    end else if (i_clk_en && i_sfr.rd && i_sfr.addr == cammc_pkg::ADDR_CNT_LOW) begin
      snap_high_q <= count_q[15:8];
    end
  end

  // ********************************************************
  // per-module mode, compare value, flag and pin
  // ********************************************************
  for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
    logic        rise;
    logic        fall;
    logic        capture;
    logic        match;
    logic        cmp_on;
    logic [15:0] mask;
    logic        pwm_level;

    assign rise    = pin_sync_q[m] & ~pin_prev_q[m];
    assign fall    = ~pin_sync_q[m] & pin_prev_q[m];
    // both enables set capture on either edge
    assign capture = (mode_q[m].rising_capture_enable & rise)
                   | (mode_q[m].falling_capture_enable & fall);
    assign cmp_on  = mode_q[m].comparator_enable;
    // short cycle compares only the low CYCLE_BITS bits
    assign mask    = mode_q[m].wide_pulse_mode_select ? 16'hFFFF
                   : 16'((32'h1 << CYCLE_BITS) - 1);
    assign match   = cmp_on & ((count_q & mask) == (cc_q[m] & mask));
    assign pwm_level = (count_q & mask) >= (cc_q[m] & mask);

    // mode register; watchdog module locked while the watchdog runs
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        mode_q[m] <= cammc_pkg::MODE_RESET;
      end else if (wr_ok && !(m == cammc_pkg::WDOG_MODULE && wdog_en)) begin
        if (mode_index(i_sfr.addr) == m) begin
          mode_q[m] <= i_sfr.wdata;
        end else if (cc_low_index(i_sfr.addr) == m) begin
          mode_q[m].comparator_enable <= 1'b0;
        end else if (cc_high_index(i_sfr.addr) == m) begin
          mode_q[m].comparator_enable <= 1'b1;
        end
      end
    end

    // compare value: software writes, capture loads counter
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        cc_q[m] <= 16'h0000;
      end else if (i_clk_en) begin
        if (capture) begin
          cc_q[m] <= count_q;
        end else if (i_sfr.wr && cc_low_index(i_sfr.addr) == m) begin
          cc_q[m][7:0] <= i_sfr.wdata;
        end else if (i_sfr.wr && cc_high_index(i_sfr.addr) == m) begin
          cc_q[m][15:8] <= i_sfr.wdata;
        end
      end
    end

    // flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        flag_q[m] <= 1'b0;
      end else if (i_clk_en) begin
        if (capture || (match && mode_q[m].match_enable)) begin
          flag_q[m] <= 1'b1;
        end else if (i_sfr.wr && i_sfr.addr == cammc_pkg::ADDR_FLAGS) begin
          flag_q[m] <= i_sfr.wdata[m];
        end
      end
    end

    // pin: toggle, frequency output or modulated level
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        o_module_io_pin[m] <= 1'b0;
      end else if (i_clk_en) begin
        if (mode_q[m].toggle_enable && match) begin
          o_module_io_pin[m] <= ~o_module_io_pin[m];
        end else if (mode_q[m].pulse_width_enable && !mode_q[m].toggle_enable && cmp_on) begin
          o_module_io_pin[m] <= pwm_level;
        end
      end
    end

    // interrupt request gated by the module's enable
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        o_irq[m] <= 1'b0;
      end else if (i_clk_en) begin
        o_irq[m] <= flag_q[m] & mode_q[m].flag_interrupt_enable;
      end
    end
  end

  // ********************************************************
  // read data, registered one cycle after the read strobe
  // ********************************************************
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en && i_sfr.rd) begin
      if (mode_index(i_sfr.addr) < NUM_MODULES) begin
        o_rdata <= mode_q[mode_index(i_sfr.addr)];
      end else if (cc_low_index(i_sfr.addr) < NUM_MODULES) begin
        o_rdata <= cc_q[cc_low_index(i_sfr.addr)][7:0];
      end else if (cc_high_index(i_sfr.addr) < NUM_MODULES) begin
        o_rdata <= cc_q[cc_high_index(i_sfr.addr)][15:8];
      end else if (i_sfr.addr == cammc_pkg::ADDR_CNT_LOW) begin
        o_rdata <= count_q[7:0];
      end else if (i_sfr.addr == cammc_pkg::ADDR_CNT_HIGH) begin
        o_rdata <= snap_high_q;
      end else if (i_sfr.addr == cammc_pkg::ADDR_CTRL) begin
        o_rdata <= ctrl_q;
      end else if (i_sfr.addr == cammc_pkg::ADDR_FLAGS) begin
        o_rdata <= {2'b00, flag_q};
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule

`default_nettype wire

// >>> rtl/cammc_pkg.sv
// package: register map, field positions and carriers of the counter array mode control
package cammc_pkg;
  // register addresses in special function register space
  localparam logic [7:0] ADDR_MODE0    = 8'hDA;
  localparam logic [7:0] ADDR_MODE1    = 8'hDB;
  localparam logic [7:0] ADDR_MODE2    = 8'hDC;
  localparam logic [7:0] ADDR_MODE3    = 8'hDD;
  localparam logic [7:0] ADDR_MODE4    = 8'hDE;
  localparam logic [7:0] ADDR_MODE5    = 8'hCE;
  localparam logic [7:0] ADDR_CNT_LOW  = 8'hF9;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'hFA;
  localparam logic [7:0] ADDR_CTRL     = 8'hD9;
  localparam logic [7:0] ADDR_CC_LOW0  = 8'hFB;
  localparam logic [7:0] ADDR_CC_LOW1  = 8'hE9;
  localparam logic [7:0] ADDR_CC_LOW2  = 8'hEB;
  localparam logic [7:0] ADDR_CC_LOW3  = 8'hED;
  localparam logic [7:0] ADDR_CC_LOW4  = 8'hFD;
  localparam logic [7:0] ADDR_CC_LOW5  = 8'hD2;
  localparam logic [7:0] ADDR_CC_HIGH0 = 8'hFC;
  localparam logic [7:0] ADDR_CC_HIGH1 = 8'hEA;
  localparam logic [7:0] ADDR_CC_HIGH2 = 8'hEC;
  localparam logic [7:0] ADDR_CC_HIGH3 = 8'hEE;
  localparam logic [7:0] ADDR_CC_HIGH4 = 8'hFE;
  localparam logic [7:0] ADDR_CC_HIGH5 = 8'hD3;
  localparam logic [7:0] ADDR_FLAGS    = 8'hD8;
  // watchdog enable position inside the control register
  localparam int         CTRL_WDOG_BIT = 6;
  // reset values and the watchdog module index
  localparam logic [7:0]  MODE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam int          WDOG_MODULE = 5;

  // one module mode register, bit 7 down to bit 0
  typedef struct packed {
    logic wide_pulse_mode_select;
    logic comparator_enable;
    logic rising_capture_enable;
    logic falling_capture_enable;
    logic match_enable;
    logic toggle_enable;
    logic pulse_width_enable;
    logic flag_interrupt_enable;
  } cammc_mode_type;

  // special function register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cammc_sfr_type;
endpackage

// >>> dv/cammc_props.sv
// checker: port-level properties of the counter array mode control
`timescale 1ns/1ps
`default_nettype none
module cammc_props #(
  parameter int NUM_MODULES = 6
) (
  input wire logic                     i_core_clk,
  input wire logic                     i_rstn,
  input wire logic                     i_clk_en,
  input wire cammc_pkg::cammc_sfr_type i_sfr,
  input wire logic [7:0]               o_rdata,
  input wire logic [NUM_MODULES-1:0]   o_module_io_pin,
  input wire logic [NUM_MODULES-1:0]   o_irq
);
  logic        wr;
  logic        rd;
  logic        wdog_q;
  logic [7:0]  a;
  logic [7:0]  m0_q;
  logic [7:0]  m5_q;
  logic [7:0]  snap_q;
  logic [15:0] cnt_q;
  assign wr = i_clk_en & i_sfr.wr;
  assign rd = i_clk_en & i_sfr.rd;
  assign a  = i_sfr.addr;
  // ********************
  // shadow registers
  // ********************
  // compare low bytes have address bit 0 opposite to high bytes, so it gives the enable level, inverted for module 0
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {wdog_q, m0_q, m5_q, snap_q, cnt_q} <= '0;
    end else if (i_clk_en) begin
      cnt_q <= cnt_q + 16'h0001;
      if (wr && a == 8'hD9) wdog_q <= i_sfr.wdata[6];
      if (wr && a == 8'hDA) m0_q <= i_sfr.wdata;
      if (wr && (a == 8'hFB || a == 8'hFC)) m0_q[6] <= ~a[0];
      if (wr && !wdog_q && a == 8'hCE) m5_q <= i_sfr.wdata;
      if (wr && !wdog_q && (a == 8'hD2 || a == 8'hD3)) m5_q[6] <= a[0];
      if (wr && !wdog_q && a == 8'hF9) cnt_q <= {cnt_q[15:8], i_sfr.wdata};
      if (wr && !wdog_q && a == 8'hFA) cnt_q <= {i_sfr.wdata, cnt_q[7:0]};
      if (rd && a == 8'hF9) snap_q <= cnt_q[15:8];
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence rd_of(logic [7:0] ad);
    rd && a == ad;
  endsequence
  // a compare byte write followed at once by a mode 0 read
  sequence cc_then_rd(logic [7:0] ad);
    wr && a == ad ##1 rd_of(8'hDA);
  endsequence
  AST_MODE0_RD: assert property (rd_of(8'hDA) |=> o_rdata == $past(m0_q)) else $error("mode 0 read");
  AST_MODE5_LOCK: assert property (rd_of(8'hCE) |=> o_rdata == $past(m5_q)) else $error("mode 5 read");
  AST_CNT_LOW: assert property (rd_of(8'hF9) |=> o_rdata == $past(cnt_q[7:0])) else $error("count low");
  AST_CNT_SNAP: assert property (rd_of(8'hFA) |=> o_rdata == $past(snap_q)) else $error("count high");
  AST_ECOM_CLR: assert property (cc_then_rd(8'hFB) |=> !o_rdata[6]) else $error("enable not cleared");
  AST_ECOM_SET: assert property (cc_then_rd(8'hFC) |=> o_rdata[6]) else $error("enable not set");
  AST_IRQ0_MASK: assert property (o_irq[0] |-> $past(m0_q[0])) else $error("irq 0 unmasked");
  AST_IRQ5_MASK: assert property (o_irq[5] |-> $past(m5_q[0])) else $error("irq 5 unmasked");
endmodule
bind cammc_top cammc_props #(.NUM_MODULES(NUM_MODULES)) props_i (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_sfr(i_sfr),
  .o_rdata(o_rdata), .o_module_io_pin(o_module_io_pin), .o_irq(o_irq));
`default_nettype wire

// >>> dv/cammc_top_tb.sv
// testbench: register, counter, pin and capture checks of the counter array mode control
`timescale 1ns/1ps
`default_nettype none
module cammc_top_tb;
  typedef struct packed {logic en; logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} cammc_row_type;
  logic                     i_core_clk = 1'b0;
  logic                     i_rstn     = 1'b0;
  logic                     i_clk_en   = 1'b1;
  cammc_pkg::cammc_sfr_type i_sfr      = '0;
  logic [5:0]               pin_in     = 6'h00;
  logic [7:0]               o_rdata;
  logic [5:0]               pin_out;
  logic [5:0]               o_irq;
  logic [7:0]               v;
  int                       err_count   = 0;
  int                       comparisons = 0;
  int                       cycles      = 0;
  int                       hi;
  int                       tg;
  // write then read back; the en-low row must leave mode 0 frozen
  cammc_row_type rows [15] = '{'{1, 8'hDA, 8'hA5, 8'hDA, 8'hA5}, '{1, 8'hDB, 8'hA5, 8'hDB, 8'hA5},
    '{1, 8'hDC, 8'hA5, 8'hDC, 8'hA5}, '{1, 8'hDD, 8'hA5, 8'hDD, 8'hA5}, '{1, 8'hDE, 8'hA5, 8'hDE, 8'hA5},
    '{1, 8'hCE, 8'hA5, 8'hCE, 8'hA5}, '{1, 8'hFC, 8'h00, 8'hDA, 8'hE5}, '{1, 8'hFB, 8'h00, 8'hDA, 8'hA5},
    '{0, 8'hDA, 8'hFF, 8'hDA, 8'hA5}, '{1, 8'hD9, 8'h40, 8'hCE, 8'hA5}, '{1, 8'hCE, 8'h11, 8'hCE, 8'hA5},
    '{1, 8'hD3, 8'h00, 8'hCE, 8'hA5}, '{1, 8'hD9, 8'h00, 8'hCE, 8'hA5}, '{1, 8'hCE, 8'h11, 8'hCE, 8'h11},
    '{1, 8'h00, 8'h00, 8'h01, 8'h00}};
  // result bits: 4 pin toggles once, 3 match flag set, 0 interrupt raised
  logic [7:0] mt_mode [4] = '{8'h4D, 8'h4C, 8'h0C, 8'h46};
  logic [7:0] mt_res [4] = '{8'h19, 8'h18, 8'h00, 8'h10};
  logic [7:0] cap_mode [6] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h30, 8'h30};
  logic       cap_rise [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] cap_flag [6] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02, 8'h02};
  cammc_top DUT (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_sfr(i_sfr),
    .i_module_io_pin(pin_in), .o_rdata(o_rdata), .o_module_io_pin(pin_out), .o_irq(o_irq));
  always #5 i_core_clk = ~i_core_clk;
  // ********************
  // bench tasks
  // ********************
  task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one access per edge, so back-to-back calls never assign twice in one step
  task automatic acc(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_core_clk);
    i_clk_en <= 1'b1;
    i_sfr    <= '{w, r, ad, d};
  endtask
  task automatic rdv(input logic [7:0] ad, output logic [7:0] q);
    acc(1'b0, 1'b1, ad, 8'h00);
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    #1 q = o_rdata;
  endtask
  // settle a few cycles so a mode switch glitch is not counted as a toggle
  task automatic watch(input int n);
    logic p;
    acc(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (4) @(posedge i_core_clk);
    hi = 0;
    tg = 0;
    #1 p = pin_out[0];
    repeat (n) begin
      @(posedge i_core_clk);
      #1;
      hi += int'(pin_out[0]);
      tg += int'(pin_out[0] != p);
      p = pin_out[0];
    end
  endtask
  // hang guard well above the expected run of some 1100 cycles
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end
  // main sequence
  initial begin
    repeat (6) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    foreach (rows[i]) begin
      @(posedge i_core_clk);
      i_clk_en <= rows[i].en;
      i_sfr    <= '{1'b1, 1'b0, rows[i].wa, rows[i].wd};
      rdv(rows[i].ra, v);
      check("register", v, rows[i].ex);
    end
    @(posedge i_core_clk);
    i_rstn <= 1'b0;
    #1 check("irq in reset", {2'b00, o_irq}, 8'h00);
    repeat (2) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rdv(rows[i].wa, v);
      check("reset value", v, 8'h00);
    end
    acc(1'b1, 1'b0, 8'hFA, 8'h12);
    acc(1'b1, 1'b0, 8'hF9, 8'h34);
    rdv(8'hF9, v);
    check("count low", v, 8'h34);
    rdv(8'hFA, v);
    check("count high", v, 8'h12);
    acc(1'b1, 1'b0, 8'hD9, 8'h40);
    acc(1'b1, 1'b0, 8'hFA, 8'h77);
    // a low byte of FF that got through would carry into the high byte
    acc(1'b1, 1'b0, 8'hF9, 8'hFF);
    rdv(8'hF9, v);
    rdv(8'hFA, v);
    check("locked high", v, 8'h12);
    acc(1'b1, 1'b0, 8'hD9, 8'h00);
    acc(1'b1, 1'b0, 8'hFB, 8'h80);
    acc(1'b1, 1'b0, 8'hFC, 8'h00);
    acc(1'b1, 1'b0, 8'hDA, 8'h42);
    watch(256);
    check("pwm high cycles", 8'(hi), 8'h80);
    acc(1'b1, 1'b0, 8'hFC, 8'h01);
    acc(1'b1, 1'b0, 8'hFA, 8'h00);
    acc(1'b1, 1'b0, 8'hF9, 8'h00);
    acc(1'b1, 1'b0, 8'hDA, 8'hC2);
    watch(200);
    check("wide pwm high cycles", 8'(hi), 8'h00);
    acc(1'b1, 1'b0, 8'hFB, 8'h10);
    acc(1'b1, 1'b0, 8'hFC, 8'h00);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b0, 8'hD8, 8'h00);
      acc(1'b1, 1'b0, 8'hFA, 8'h00);
      acc(1'b1, 1'b0, 8'hF9, 8'h00);
      acc(1'b1, 1'b0, 8'hDA, mt_mode[i]);
      watch(100);
      check("toggles", 8'(tg), {7'h00, mt_res[i][4]});
      check("irq", {2'b00, o_irq}, {7'h00, mt_res[i][0]});
      rdv(8'hD8, v);
      check("match flag", v & 8'h3F, {7'h00, mt_res[i][3]});
    end
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 1'b0, 8'hDB, cap_mode[i]);
      pin_in[1] <= ~cap_rise[i];
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (5) @(posedge i_core_clk);
      // drop the strobe at once: a clear held for several cycles would wipe the captured flag
      acc(1'b1, 1'b0, 8'hD8, 8'h00);
      pin_in[1] <= cap_rise[i];
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (5) @(posedge i_core_clk);
      rdv(8'hD8, v);
      check("capture flag", v & 8'h3F, cap_flag[i]);
    end
    results();
  end
endmodule
`default_nettype wire
